// >>> pkg/bcd_map.svh
// control, status and diagnostic bit positions for the channel adapter
`ifndef BCD_MAP_SVH
`define BCD_MAP_SVH
`define BCD_CTL_OP_BIT     3'd0
`define BCD_CTL_MODE_BIT   3'd1
`define BCD_CTL_PACE_BIT   3'd2
`define BCD_CTL_IEN1_BIT   3'd3
`define BCD_CTL_IEN2_BIT   3'd4
`define BCD_STAT_S1_BIT    3'd5
`define BCD_STAT_S2_BIT    3'd4
`define BCD_DIAG_RATE_BIT  3'd0
`endif

// >>> pkg/bcd_pkg.sv
// types shared by the channel adapter
`default_nettype none
package bcd_pkg;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_ORDER  = 4'h1,
    ST_STAT0  = 4'h2,
    ST_CTL    = 4'h3,
    ST_ADDR   = 4'h4,
    ST_WDATA  = 4'h5,
    ST_PACE   = 4'h6,
    ST_STROBE = 4'h7,
    ST_RDATA  = 4'h8,
    ST_STATN  = 4'h9
  } bcd_state_t;
  typedef struct packed {
    logic        strobe;
    logic        write;
    logic [15:0] addr;
    logic [31:0] data;
  } bcd_dio_req_t;
endpackage
`default_nettype wire

// >>> core/bcd_adapter.sv
// list-driven byte channel to direct i/o adapter
// Behaviour
// - first order byte fetched then ignored
// - previous status stored in list byte zero
// - fetch control byte then two address bytes
// - write op fetches four data bytes then strobes
// - mode 1 writes status into bits 2,3 next byte
// - read op drives address only, waits ack
// - read data to four bytes, then status byte in mode 1
// - last op status held for next list
// - mode 1 repeats control and address
// - mode 2 reuses first control and address
// - runs whole list without processor help
// - optional pacing by external rate pulse
// - no stalls beyond channel and device waits, and rate pulse waits when paced
// - test device reads rate error and status
// - one byte channel, own direct port
// - control bit 8 selects write or read
// - control bit 9 selects list mode
// - control bit 10 selects rate pacing
// - control bits 11,12 enable status interrupts
`timescale 1ns/1ps
`default_nettype none
`include "bcd_map.svh"
module bcd_adapter (
  input  wire logic                  mclk_in,
  input  wire logic                  resetn_in,
  input  wire logic                  start_io_instruction_in,
  input  wire logic                  test_device_instruction_in,
  input  wire logic                  chan_rd_valid_in,
  input  wire logic [7:0]            chan_rd_data_in,
  input  wire logic                  chan_wr_done_in,
  input  wire logic                  chan_count_done_in,
  input  wire logic                  dio_ack_in,
  input  wire logic                  first_status_line_in,
  input  wire logic                  second_status_line_in,
  input  wire logic [31:0]           dio_data_in,
  input  wire logic                  rate_pulse_in,
  output logic                       chan_rd_req_out,
  output logic                       chan_wr_req_out,
  output logic [7:0]                 chan_wr_data_out,
  output logic                       busy_out,
  output logic                       irq_out,
  output logic [7:0]                 tdv_data_out,
  output logic                       tdv_valid_out,
  output bcd_pkg::bcd_dio_req_t      dio_req_out,      // own direct port
  output logic [31:0]                dio_data_out,
  output logic                       dio_data_oen_out
);
  bcd_pkg::bcd_state_t state;
  logic [7:0]  ctl;
  logic [1:0]  cnt;
  logic [1:0]  held_stat;
  logic        rate_err;
  logic        rate_seen;
  logic        first_op;
  logic        chan_hs;

  // a channel handshake done this cycle
  assign chan_hs = chan_rd_valid_in | chan_wr_done_in;

  // status byte layout: bits 2,3 in msb-first numbering
  function automatic logic [7:0] stat_byte(input logic [1:0] s);
    logic [7:0] b;
    b = 8'h00;
    b[`BCD_STAT_S1_BIT] = s[0];
    b[`BCD_STAT_S2_BIT] = s[1];
    return b;
  endfunction

  // main list sequencer
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state            <= bcd_pkg::ST_IDLE;
      ctl              <= 8'h00;
      cnt              <= 2'h0;
      first_op         <= 1'b0;
      chan_rd_req_out  <= 1'b0;
      chan_wr_req_out  <= 1'b0;
      chan_wr_data_out <= 8'h00;
      dio_req_out      <= '0;
      dio_data_out     <= 32'h0000_0000;
      dio_data_oen_out <= 1'b1;
      held_stat        <= 2'h0;
      busy_out         <= 1'b0;
      irq_out          <= 1'b0;
    end
    else
    begin
      irq_out <= 1'b0;
      case (state)
        bcd_pkg::ST_IDLE:
          if (start_io_instruction_in)
          begin
            state           <= bcd_pkg::ST_ORDER;
            busy_out        <= 1'b1;
            chan_rd_req_out <= 1'b1;
          end
        bcd_pkg::ST_ORDER:
          if (chan_rd_valid_in)
          begin
            // order byte dropped, no interrupt
            chan_rd_req_out  <= 1'b0;
            chan_wr_req_out  <= 1'b1;
            chan_wr_data_out <= stat_byte(held_stat);
            state            <= bcd_pkg::ST_STAT0;
          end
        bcd_pkg::ST_STAT0:
          if (chan_wr_done_in)
          begin
            chan_wr_req_out <= 1'b0;
            chan_rd_req_out <= 1'b1;
            first_op        <= 1'b1;
            state           <= bcd_pkg::ST_CTL;
          end
        bcd_pkg::ST_CTL:
          if (chan_rd_valid_in)
          begin
            ctl   <= chan_rd_data_in;
            cnt   <= 2'h0;
            state <= bcd_pkg::ST_ADDR;
          end
        bcd_pkg::ST_ADDR:
          if (chan_rd_valid_in)
          begin
            // high address byte first
            dio_req_out.addr <= {dio_req_out.addr[7:0], chan_rd_data_in};
            cnt <= cnt + 2'h1;
            if (cnt == 2'h1)
            begin
              cnt <= 2'h0;
              if (ctl[`BCD_CTL_OP_BIT]) // write op
                state <= bcd_pkg::ST_WDATA;
              else
              begin
                chan_rd_req_out <= 1'b0; // address only
                state           <= bcd_pkg::ST_PACE;
              end
            end
          end
        bcd_pkg::ST_WDATA:
          if (chan_rd_valid_in)
          begin
            dio_data_out <= {dio_data_out[23:0], chan_rd_data_in};
            cnt <= cnt + 2'h1;
            if (cnt == 2'h3)
            begin
              chan_rd_req_out <= 1'b0;
              state           <= bcd_pkg::ST_PACE;
            end
          end
          else if (chan_count_done_in)
          begin
            chan_rd_req_out <= 1'b0;
            busy_out        <= 1'b0;
            state           <= bcd_pkg::ST_IDLE;
          end
        bcd_pkg::ST_PACE:
          // wait for rate pulse when paced, else no added stall
          if (!ctl[`BCD_CTL_PACE_BIT] || rate_seen || rate_pulse_in)
          begin
            dio_req_out.strobe <= 1'b1;
            dio_req_out.write  <= ctl[`BCD_CTL_OP_BIT];
            dio_data_oen_out   <= ~ctl[`BCD_CTL_OP_BIT];
            state              <= bcd_pkg::ST_STROBE;
          end
        bcd_pkg::ST_STROBE:
          if (dio_ack_in)
          begin
            dio_req_out.strobe <= 1'b0;
            dio_data_oen_out   <= 1'b1;
            held_stat <= {second_status_line_in, first_status_line_in};
            irq_out <= (ctl[`BCD_CTL_IEN1_BIT] & first_status_line_in)
                     | (ctl[`BCD_CTL_IEN2_BIT] & second_status_line_in);
            cnt <= 2'h0;
            if (!ctl[`BCD_CTL_OP_BIT])
            begin
              dio_data_out     <= dio_data_in;
              chan_wr_req_out  <= 1'b1;
              chan_wr_data_out <= dio_data_in[31:24];
              state            <= bcd_pkg::ST_RDATA;
            end
            else if (!ctl[`BCD_CTL_MODE_BIT]) // mode 1
            begin
              chan_wr_req_out  <= 1'b1;
              chan_wr_data_out <= stat_byte({second_status_line_in, first_status_line_in});
              state            <= bcd_pkg::ST_STATN;
            end
            else if (chan_count_done_in)
            begin
              busy_out <= 1'b0; // last mode 2 word sent
              state    <= bcd_pkg::ST_IDLE;
            end
            else
            begin
              chan_rd_req_out <= 1'b1; // mode 2 next word
              state           <= bcd_pkg::ST_WDATA;
            end
          end
        bcd_pkg::ST_RDATA:
          if (chan_wr_done_in)
          begin
            cnt <= cnt + 2'h1;
            dio_data_out     <= {dio_data_out[23:0], 8'h00};
            chan_wr_data_out <= dio_data_out[23:16];
            if (cnt == 2'h3)
            begin
              if (!ctl[`BCD_CTL_MODE_BIT])
              begin
                chan_wr_data_out <= stat_byte(held_stat);
                state            <= bcd_pkg::ST_STATN;
              end
              else if (chan_count_done_in)
              begin
                // last mode 2 word stored, list over
                chan_wr_req_out <= 1'b0;
                busy_out        <= 1'b0;
                state           <= bcd_pkg::ST_IDLE;
              end
              else
              begin
                chan_wr_req_out <= 1'b0;
                state           <= bcd_pkg::ST_PACE;
              end
            end
          end
          else if (chan_count_done_in)
          begin
            chan_wr_req_out <= 1'b0;
            busy_out        <= 1'b0;
            state           <= bcd_pkg::ST_IDLE;
          end
        bcd_pkg::ST_STATN:
          if (chan_wr_done_in)
          begin
            chan_wr_req_out <= 1'b0;
            chan_rd_req_out <= 1'b1;
            first_op        <= 1'b0;
            state           <= bcd_pkg::ST_CTL;
          end
          else if (chan_count_done_in)
          begin
            // final status stays held for next list
            chan_wr_req_out <= 1'b0;
            busy_out        <= 1'b0;
            state           <= bcd_pkg::ST_IDLE;
          end
        default:
          state <= bcd_pkg::ST_IDLE;
      endcase
      // count exhausted while awaiting a control byte ends the list
      if (state == bcd_pkg::ST_CTL && chan_count_done_in && !chan_rd_valid_in)
      begin
        chan_rd_req_out <= 1'b0;
        busy_out        <= 1'b0;
        state           <= bcd_pkg::ST_IDLE;
      end
    end
  end

  // rate pulse latch and sticky rate error
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rate_seen <= 1'b0;
      rate_err  <= 1'b0;
    end
    else
    begin
      if (state == bcd_pkg::ST_PACE)
        rate_seen <= 1'b0;
      else if (rate_pulse_in && busy_out && ctl[`BCD_CTL_PACE_BIT])
        rate_seen <= 1'b1;
      // early pulse while one already pending; set wins
      if (rate_pulse_in && rate_seen && state != bcd_pkg::ST_PACE)
        rate_err <= 1'b1;
      else if (test_device_instruction_in)
        rate_err <= 1'b0;
    end
  end

  // test device readback
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tdv_data_out  <= 8'h00;
      tdv_valid_out <= 1'b0;
    end
    else
    begin
      tdv_valid_out <= test_device_instruction_in;
      tdv_data_out  <= {busy_out, first_op, 2'h0, held_stat, 1'b0, rate_err};
    end
  end

  // direct port strobe ends only on acknowledge
  AST_STROBE_HOLD: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (dio_req_out.strobe && !dio_ack_in) |=> dio_req_out.strobe)
    else $error("strobe dropped without acknowledge");
  AST_ACK_ENDS: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (state == bcd_pkg::ST_STROBE && dio_ack_in) |=> !dio_req_out.strobe)
    else $error("strobe stayed after acknowledge");
  AST_PACE_WAIT: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (state == bcd_pkg::ST_PACE && ctl[2] && !rate_seen && !rate_pulse_in) |=> !dio_req_out.strobe)
    else $error("paced op started without rate pulse");
  AST_FREE_RUN: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (state == bcd_pkg::ST_PACE && !ctl[2]) |=> dio_req_out.strobe)
    else $error("unpaced op delayed");
  AST_WRITE_DIR: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    dio_req_out.strobe |-> (dio_req_out.write == ctl[0]) && (dio_data_oen_out == !ctl[0]))
    else $error("direction does not match control byte");
  AST_ORDER_IGN: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (state == bcd_pkg::ST_ORDER && chan_rd_valid_in) |=> chan_wr_req_out && !irq_out
      && chan_wr_data_out == stat_byte(held_stat))
    else $error("order byte not followed by status store");
  AST_RATE_ERR: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (rate_pulse_in && rate_seen && state != bcd_pkg::ST_PACE) |=> rate_err)
    else $error("rate error not flagged");
  AST_STAT_HELD: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (state == bcd_pkg::ST_STROBE && dio_ack_in) |=>
      held_stat == {$past(second_status_line_in), $past(first_status_line_in)})
    else $error("status not captured on acknowledge");
endmodule
`default_nettype wire

// >>> sim/bcd_partner.sv
// channel list memory and direct port device model
`timescale 1ns/1ps
`default_nettype none
module bcd_partner (
  input  wire logic                  clk_in,
  input  wire logic                  rd_req_in,
  input  wire logic                  wr_req_in,
  input  wire bcd_pkg::bcd_dio_req_t dio_req_in,
  output logic                       rd_valid_out,
  output logic [7:0]                 rd_data_out,
  output logic                       wr_done_out,
  output logic                       count_done_out,
  output logic                       ack_out,
  output logic                       st1_out,
  output logic                       st2_out,
  output logic [31:0]                dio_data_out
);
  logic [7:0]  mem [0:63];
  logic [31:0] rdw [0:7];
  int          len, ptr, k, slow, wt, dw;
  logic        first, s1, s2;
  initial
  begin
    {rd_valid_out, wr_done_out, ack_out, st1_out, st2_out} = 5'h00;
    rd_data_out  = 8'h5A;
    dio_data_out = 32'hA5A5A5A5;
    {len, ptr, k, slow, wt, dw, first} = '0;
  end
  // byte count kept here, exhausted once the list is used up
  assign count_done_out = !first && ptr >= len;
  // order byte first, then list bytes in sequence; idle data toggles
  always @(posedge clk_in)
  begin
    rd_valid_out <= 1'b0;
    wr_done_out  <= 1'b0;
    rd_data_out  <= ~rd_data_out;
    if (rd_valid_out || wr_done_out || !(rd_req_in || wr_req_in))
      wt <= 0;
    else if (wt < slow)
      wt <= wt + 1;
    else if (rd_req_in)
    begin
      rd_valid_out <= 1'b1;
      rd_data_out  <= first ? 8'h01 : mem[ptr];
      ptr          <= first ? ptr : ptr + 1;
      first        <= 1'b0;
    end
    else
    begin
      wr_done_out <= 1'b1;
      ptr         <= ptr + 1;
    end
  end
  // addressed device acks with data and status, lines toggle otherwise
  always @(posedge clk_in)
  begin
    ack_out      <= 1'b0;
    dio_data_out <= ~dio_data_out;
    st1_out      <= ~st1_out;
    st2_out      <= ~st2_out;
    if (!dio_req_in.strobe || ack_out)
      dw <= 0;
    else if (dw < slow)
      dw <= dw + 1;
    else
    begin
      ack_out      <= 1'b1;
      dio_data_out <= rdw[k];
      st1_out      <= s1;
      st2_out      <= s2;
      k            <= k + 1;
    end
  end
endmodule
`default_nettype wire

// >>> sim/bcd_adapter_tb.sv
// self-checking bench for the channel adapter
`timescale 1ns/1ps
`default_nettype none
`include "bcd_map.svh"
module bcd_adapter_tb;
  logic mclk_in = 1'b0, resetn_in = 1'b0, start = 1'b0, test_device_instruction = 1'b0, rate = 1'b0;
  logic rd_v, wr_d, cnt_d, ack, st1, st2, rd_r, wr_r, irq, busy, tdv_v, oen, irq_n, pace_on, ps1, ps2;
  logic [7:0]  rd_b, wr_b, tdv_b, cur_ctl;
  logic [31:0] dio_in, dio_out;
  logic [15:0] lf = 16'h0045;
  bcd_pkg::bcd_dio_req_t dio_req;
  logic [7:0]  exp_b [$];
  logic [7:0]  exp_t [$];
  logic [31:0] exp_d [$];
  bcd_pkg::bcd_dio_req_t exp_r [$];
  int failures = 0, num_checks = 0, pc = 0, per = 0, tn = 0;
  initial {irq_n, pace_on, ps1, ps2, cur_ctl} = '0;
  always #20 mclk_in = ~mclk_in;
  bcd_adapter i_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .start_io_instruction_in(start),
    .test_device_instruction_in(test_device_instruction), .chan_rd_valid_in(rd_v), .chan_rd_data_in(rd_b),
    .chan_wr_done_in(wr_d), .chan_count_done_in(cnt_d), .dio_ack_in(ack), .first_status_line_in(st1),
    .second_status_line_in(st2), .dio_data_in(dio_in), .rate_pulse_in(rate), .chan_rd_req_out(rd_r),
    .chan_wr_req_out(wr_r), .chan_wr_data_out(wr_b), .busy_out(busy), .irq_out(irq), .tdv_data_out(tdv_b),
    .tdv_valid_out(tdv_v), .dio_req_out(dio_req), .dio_data_out(dio_out), .dio_data_oen_out(oen));
  bcd_partner i_part (.clk_in(mclk_in), .rd_req_in(rd_r), .wr_req_in(wr_r), .dio_req_in(dio_req),
    .rd_valid_out(rd_v), .rd_data_out(rd_b), .wr_done_out(wr_d), .count_done_out(cnt_d), .ack_out(ack),
    .st1_out(st1), .st2_out(st2), .dio_data_out(dio_in));
  function automatic logic [15:0] next_rand();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  function automatic logic [7:0] stb(input logic a, input logic b);
    stb = 8'h00;
    stb[`BCD_STAT_S1_BIT] = a;
    stb[`BCD_STAT_S2_BIT] = b;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // external rate pulses while pacing is on
  always @(posedge mclk_in)
  begin
    pc <= pc + 1;
    rate <= pace_on && per != 0 && (pc % per == 0);
  end
  // monitor: compare each result with the oldest note
  always @(posedge mclk_in)
  begin
    if (resetn_in)
      check(irq, irq_n);
    irq_n = 1'b0;
    if (wr_r && wr_d)
      check(wr_b, exp_b.size() ? exp_b.pop_front() : 'x);
    if (dio_req.strobe && ack)
    begin
      check(dio_req, exp_r.size() ? exp_r.pop_front() : 'x);
      check(oen, !dio_req.write);
      if (dio_req.write)
        check(dio_out, exp_d.size() ? exp_d.pop_front() : 'x);
      irq_n = (cur_ctl[`BCD_CTL_IEN1_BIT] & i_part.s1) | (cur_ctl[`BCD_CTL_IEN2_BIT] & i_part.s2);
    end
    if (tdv_v)
      check(tdv_b, exp_t.size() ? exp_t.pop_front() : 'x);
  end
  // build one list, note results, start and wait for the end
  task automatic run(input logic [7:0] ctl, input int n, input logic a1, input logic a2, input int sl,
                     input int pr, input logic hold);
    int i, j, p;
    logic md;
    logic [7:0] c;
    logic [15:0] ad;
    logic [31:0] d;
    md = ctl[`BCD_CTL_MODE_BIT];
    cur_ctl = ctl;
    i_part.slow  = sl;
    i_part.s1    = a1;
    i_part.s2    = a2;
    i_part.ptr   = 0;
    i_part.k     = 0;
    i_part.first = 1'b1;
    exp_b.push_back(stb(ps1, ps2));
    p = 1;
    for (i = 0; i < n; i++)
    begin
      c = ctl;
      c[`BCD_CTL_OP_BIT] = ctl[`BCD_CTL_OP_BIT] ^ (!md & i[0]);
      if (i == 0 || !md)
      begin
        ad = next_rand();
        {i_part.mem[p], i_part.mem[p + 1], i_part.mem[p + 2]} = {c, ad};
        p += 3;
      end
      d = {next_rand(), next_rand()};
      i_part.rdw[i] = d;
      exp_r.push_back({1'b1, c[`BCD_CTL_OP_BIT], ad, 32'h0});
      for (j = 0; j < 4; j++)
      begin
        i_part.mem[p + j] = d[31 - 8 * j -: 8];
        if (!c[`BCD_CTL_OP_BIT])
          exp_b.push_back(d[31 - 8 * j -: 8]);
      end
      if (c[`BCD_CTL_OP_BIT])
        exp_d.push_back(d);
      p += md ? 4 : 5;
      if (!md)
        exp_b.push_back(stb(a1, a2));
    end
    i_part.len = p;
    {ps1, ps2} = {a1, a2};
    @(posedge mclk_in) start <= 1'b1;
    @(posedge mclk_in) start <= 1'b0;
    repeat (3) @(posedge mclk_in);
    start <= 1'b1; // refused while busy
    @(posedge mclk_in) start <= 1'b0;
    if (hold)
    begin
      repeat (60) @(posedge mclk_in);
      check(dio_req.strobe, 1'b0);
      check(exp_r.size(), n);
    end
    per = pr;
    pace_on = pr != 0;
    for (i = 0; i < 3000 && busy !== 1'b0; i++)
      @(posedge mclk_in);
    pace_on = 1'b0;
    check(busy, 1'b0);
    check(exp_b.size() + exp_r.size() + exp_d.size(), 0);
    tn++;
    $display("test %0d done", tn);
  endtask
  task automatic read_diag(input logic r);
    exp_t.push_back({1'b0, 1'b1, 2'h0, ps2, ps1, 1'b0, r}); // idle, first-op flag left set by mode 2
    @(posedge mclk_in) test_device_instruction <= 1'b1;
    @(posedge mclk_in) test_device_instruction <= 1'b0;
    repeat (3) @(posedge mclk_in);
    check(exp_t.size(), 0);
  endtask
  initial
  begin
    repeat (2) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    run(8'h09, 3, 1'b1, 1'b0, 0, 0, 1'b0);
    run(8'h02, 3, 1'b0, 1'b1, 3, 0, 1'b0);
    run(8'h13, 2, 1'b1, 1'b1, 1, 0, 1'b0);
    read_diag(1'b0);
    run(8'h00, 1, 1'b0, 1'b0, 2, 0, 1'b0);
    run(8'h07, 2, 1'b1, 1'b0, 0, 40, 1'b1);
    read_diag(1'b0);
    run(8'h06, 2, 1'b0, 1'b1, 10, 3, 1'b0);
    read_diag(1'b1);
    read_diag(1'b0);
    end_sim();
  end
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
